//--- rtl/irp_bus_if.sv
interface irp_bus_if;
   logic scl_m_o;
   logic scl_m_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic scl_d_o;
   logic scl_d_oe_n;
   logic sda_d_o;
   logic sda_d_oe_n;
   logic scl;
   logic sda;

   // Wired-AND with pull-ups
   assign scl = (scl_m_oe_n | scl_m_o) & (scl_d_oe_n | scl_d_o);
   assign sda = (sda_m_oe_n | sda_m_o) & (sda_d_oe_n | sda_d_o);

   modport master (output scl_m_o, scl_m_oe_n, sda_m_o, sda_m_oe_n, input scl, sda);
   modport target (output scl_d_o, scl_d_oe_n, sda_d_o, sda_d_oe_n, input scl, sda);
endinterface

//--- rtl/irp_master.sv
module irp_master (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Bus
   irp_bus_if.master       bus,
   // Command
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_read,
   input  wire logic       cmd_addr_low,
   input  wire logic [7:0] cmd_ptr,
   input  wire logic [7:0] cmd_len,
   // Write data
   input  wire logic [7:0] wr_data,
   output logic            wr_take,
   // Read data
   output logic            rd_valid,
   output logic [7:0]      rd_data,
   // Completion
   output logic            done,
   output logic            nack_err
);
   irp_pkg::irp_host_state_e hstate;
   logic [1:0] line_q;
   logic       sym_busy;
   logic [1:0] phase;
   logic [7:0] tcnt;
   logic [1:0] kind;
   logic       sample;
   logic       scl_low;
   logic       sda_low;
   logic       launched;
   logic [3:0] bitn;
   logic [8:0] tx;
   logic [8:0] rx;
   logic [7:0] left;
   logic       rd;
   logic       alow;
   logic [7:0] ptr;

   irp_sync2 #(.W(2), .RST_VAL(2'h3)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({bus.scl, bus.sda}),
      .q   (line_q)
   );

   wire       scl_s   = line_q[1];
   wire       sda_s   = line_q[0];
   wire       idle    = ~sym_busy;
   wire       in_byte = hstate inside {irp_pkg::H_ADDR_W, irp_pkg::H_PTR, irp_pkg::H_WDATA,
                                       irp_pkg::H_ADDR_R, irp_pkg::H_RDATA};
   wire       go_st   = idle & ~launched & (hstate inside {irp_pkg::H_START, irp_pkg::H_RSTART});
   wire       go_sp   = idle & ~launched & (hstate == irp_pkg::H_STOP);
   wire       go_bit  = idle & in_byte & (bitn != irp_pkg::SLOT_BITS);
   wire       eval    = idle & in_byte & (bitn == irp_pkg::SLOT_BITS);
   wire       sym_go  = go_st | go_sp | go_bit;
   wire [1:0] go_kind = go_st ? irp_pkg::SYM_START : go_sp ? irp_pkg::SYM_STOP : irp_pkg::SYM_BIT;
   wire [8:0] rx_next = {rx[7:0], sample};
   wire       nack    = rx_next[0];
   wire [7:0] phase_ld = (phase == 2'h0) ? irp_pkg::Q_HIGH_LD :
                         (phase == 2'h1) ? irp_pkg::Q_HIGH_LD : irp_pkg::Q_LOW_LD;

   assign cmd_ready      = hstate == irp_pkg::H_IDLE;
   assign bus.scl_m_o    = 1'b0;
   assign bus.sda_m_o    = 1'b0;
   assign bus.scl_m_oe_n = ~scl_low;
   assign bus.sda_m_oe_n = ~sda_low;

   // Four-phase symbol engine; phase 1 waits while the target stretches
   always_ff @(posedge clk) begin
      if (rst) begin
         sym_busy <= 1'b0;
         phase    <= 2'h0;
         tcnt     <= 8'h00;
         kind     <= irp_pkg::SYM_BIT;
         sample   <= 1'b1;
         scl_low  <= 1'b0;
         sda_low  <= 1'b0;
      end else if (sym_busy) begin
         if (phase == 2'h1 && !scl_s) begin
            tcnt <= irp_pkg::Q_HIGH_LD;
         end else if (tcnt != 8'h00) begin
            tcnt <= tcnt - 8'h01;
         end else if (phase == 2'h3) begin
            sym_busy <= 1'b0;
         end else begin
            phase <= phase + 2'h1;
            tcnt  <= phase_ld;
            if (phase == 2'h0) begin
               scl_low <= 1'b0;
            end else if (phase == 2'h1) begin
               sample  <= sda_s;
               sda_low <= (kind == irp_pkg::SYM_BIT) ? sda_low : (kind == irp_pkg::SYM_START);
            end else begin
               scl_low <= kind != irp_pkg::SYM_STOP;
            end
         end
      end else if (sym_go) begin
         sym_busy <= 1'b1;
         phase    <= 2'h0;
         tcnt     <= irp_pkg::Q_LOW_LD;
         kind     <= go_kind;
         sda_low  <= go_st ? 1'b0 : go_sp ? 1'b1 : ~tx[8];
      end
   end

   // Byte sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         hstate   <= irp_pkg::H_IDLE;
         launched <= 1'b0;
         bitn     <= 4'h0;
         tx       <= 9'h1ff;
         rx       <= 9'h1ff;
         left     <= 8'h00;
         rd       <= 1'b0;
         alow     <= 1'b0;
         ptr      <= 8'h00;
         wr_take  <= 1'b0;
         rd_valid <= 1'b0;
         rd_data  <= 8'h00;
         done     <= 1'b0;
         nack_err <= 1'b0;
      end else begin
         wr_take  <= 1'b0;
         rd_valid <= 1'b0;
         done     <= 1'b0;
         if (go_st || go_sp) begin
            launched <= 1'b1;
         end
         if (go_bit) begin
            tx   <= {tx[7:0], 1'b1};
            bitn <= bitn + 4'h1;
            if (bitn != 4'h0) begin
               rx <= rx_next;
            end
         end
         unique case (hstate)
            irp_pkg::H_IDLE: begin
               if (cmd_valid) begin
                  rd       <= cmd_read;
                  alow     <= cmd_addr_low;
                  ptr      <= cmd_ptr;
                  left     <= (cmd_read && cmd_len == 8'h00) ? 8'h01 : cmd_len;
                  nack_err <= 1'b0;
                  hstate   <= irp_pkg::H_START;
               end
            end
            irp_pkg::H_START, irp_pkg::H_RSTART: begin
               if (idle && launched) begin
                  launched <= 1'b0;
                  bitn     <= 4'h0;
                  tx       <= {irp_pkg::ADDR_HIGH, alow, hstate == irp_pkg::H_RSTART, 1'b1};
                  hstate   <= (hstate == irp_pkg::H_RSTART) ? irp_pkg::H_ADDR_R : irp_pkg::H_ADDR_W;
               end
            end
            irp_pkg::H_STOP: begin
               if (idle && launched) begin
                  launched <= 1'b0;
                  done     <= 1'b1;
                  hstate   <= irp_pkg::H_IDLE;
               end
            end
            default: begin
               if (eval) begin
                  bitn <= 4'h0;
                  if (hstate == irp_pkg::H_RDATA) begin
                     rd_valid <= 1'b1;
                     rd_data  <= rx_next[8:1];
                     left     <= left - 8'h01;
                     tx       <= {8'hff, left == 8'h02};
                     hstate   <= (left == 8'h01) ? irp_pkg::H_STOP : irp_pkg::H_RDATA;
                  end else if (nack) begin
                     nack_err <= 1'b1;
                     hstate   <= irp_pkg::H_STOP;
                  end else if (hstate == irp_pkg::H_ADDR_W) begin
                     tx     <= {ptr, 1'b1};
                     hstate <= irp_pkg::H_PTR;
                  end else if (hstate == irp_pkg::H_ADDR_R) begin
                     tx     <= {8'hff, left == 8'h01};
                     hstate <= irp_pkg::H_RDATA;
                  end else if (rd) begin
                     hstate <= irp_pkg::H_RSTART;
                  end else if (left != 8'h00) begin
                     tx      <= {wr_data, 1'b1};
                     wr_take <= 1'b1;
                     left    <= left - 8'h01;
                     hstate  <= irp_pkg::H_WDATA;
                  end else begin
                     hstate <= irp_pkg::H_STOP;
                  end
               end
            end
         endcase
      end
   end
endmodule

//--- rtl/irp_pkg.sv
package irp_pkg;
   // Bus address and framing
   localparam logic [5:0] ADDR_HIGH      = 6'h34;
   localparam int         BYTE_BITS      = 8;
   localparam logic [3:0] RX_BITS        = 4'h8;
   localparam logic [3:0] TX_LAST        = 4'h7;
   localparam logic [3:0] SLOT_BITS      = 4'h9;

   // Bus timing
   localparam int         CLK_MHZ        = 100;
   localparam int         SCL_MAX_KHZ    = 400;
   localparam int         SCL_PERIOD_NS  = 1000000 / SCL_MAX_KHZ;
   localparam int         T_LOW_NS       = 1300;
   localparam int         Q_LOW_CYC      = (T_LOW_NS * CLK_MHZ + 1999) / 2000;
   localparam int         Q_HIGH_CYC     = ((SCL_PERIOD_NS - T_LOW_NS) * CLK_MHZ) / 2000;
   localparam logic [7:0] Q_LOW_LD       = 8'(Q_LOW_CYC - 1);
   localparam logic [7:0] Q_HIGH_LD      = 8'(Q_HIGH_CYC - 1);

   // Register map
   localparam logic [7:0] REG_CFG_BASE   = 8'h00;
   localparam int         CFG_NUM        = 8;
   localparam logic [7:0] CFG_NUM_B      = 8'h08;
   localparam logic [7:0] CFG_RESET      = 8'h00;
   localparam logic [7:0] REG_SENS_BASE  = 8'h10;
   localparam int         SENS_BYTES     = 8;
   localparam logic [7:0] SENS_NUM_B     = 8'h08;
   localparam logic [7:0] REG_FIFO_CNT_H = 8'h18;
   localparam logic [7:0] REG_FIFO_CNT_L = 8'h19;
   localparam logic [7:0] REG_FIFO_DATA  = 8'h1a;
   localparam logic [7:0] REG_IDENTITY   = 8'h1b;

   // Sample buffer
   localparam int         FIFO_DEPTH     = 512;
   localparam int         FIFO_AW        = 9;
   localparam logic [9:0] FIFO_FULL_CNT  = 10'h200;

   // Synchroniser idle value: lines high, toggle and strap low
   localparam logic [3:0] SYNC_LINK_RST  = 4'hc;

   // Host symbol kinds
   localparam logic [1:0] SYM_BIT        = 2'h0;
   localparam logic [1:0] SYM_START      = 2'h1;
   localparam logic [1:0] SYM_STOP       = 2'h2;

   typedef enum logic [7:0] {
      D_IDLE   = 8'h01,
      D_ADDR   = 8'h02,
      D_ACK_A  = 8'h04,
      D_RX     = 8'h08,
      D_ACK_RX = 8'h10,
      D_TX     = 8'h20,
      D_ACK_TX = 8'h40,
      D_WAIT   = 8'h80
   } irp_dev_state_e;

   typedef enum logic [8:0] {
      H_IDLE   = 9'h001,
      H_START  = 9'h002,
      H_ADDR_W = 9'h004,
      H_PTR    = 9'h008,
      H_WDATA  = 9'h010,
      H_RSTART = 9'h020,
      H_ADDR_R = 9'h040,
      H_RDATA  = 9'h080,
      H_STOP   = 9'h100
   } irp_host_state_e;
endpackage

//--- rtl/irp_sync2.sv
module irp_sync2 #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

//--- rtl/irp_target.sv
// How it works
// - Acts only as bus target, never initiates
// - Address 110100 plus strap pin low bit
// - Identity register returns own bus address
// - Works with bus clock up to 400 kHz
// - Falling data while clock high is START
// - Rising data while clock high is STOP
// - Busy until STOP; repeated START rematches address
// - Bytes shifted in units of eight bits
// - No limit on bytes per transfer
// - Receiver holds data low during ack pulse
// - Master reaches registers, status and data
// - Sensor bytes read-only, always current
// - Repeated FIFO reads give consecutive bytes
// - Readable FIFO byte count kept current
// - Address plus direction bit; ack on match
// - First written byte is pointer, then autoincrement except at FIFO data
// - Master: pointer write, restart, read, nack last
// - Nack after sent byte ends read data
module irp_target (
   // Link side
   input  wire logic        link_clk,
   input  wire logic        link_rst,
   irp_bus_if.target        bus,
   // Register side
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        address_low_bit_strap,
   // Sensor samples
   input  wire logic [15:0] rate_x,
   input  wire logic [15:0] rate_y,
   input  wire logic [15:0] rate_z,
   input  wire logic [15:0] temp_sample,
   // Sample buffer fill
   input  wire logic        fifo_push_valid,
   input  wire logic [7:0]  fifo_push_data,
   output logic             fifo_push_ready,
   output logic [9:0]       fifo_count,
   // Configuration bytes
   output logic [63:0]      cfg_bits
);
   irp_pkg::irp_dev_state_e state;
   logic [3:0]  ls_q;
   logic        scl_q;
   logic        sda_q;
   logic [7:0]  sh;
   logic [3:0]  cnt;
   logic        rw;
   logic        first;
   logic [7:0]  ptr;
   logic        wr_pend;
   logic        sda_low;
   logic        req_t;
   logic        req_we;
   logic [7:0]  req_addr;
   logic [7:0]  req_wdata;
   logic        ack_seen;
   logic        ack_t;
   logic [7:0]  rdata;

   irp_sync2 #(.W(4), .RST_VAL(irp_pkg::SYNC_LINK_RST)) u_link_sync (
      .clk (link_clk),
      .rst (link_rst),
      .d   ({bus.scl, bus.sda, ack_t, address_low_bit_strap}),
      .q   (ls_q)
   );

   wire scl_s     = ls_q[3];
   wire sda_s     = ls_q[2];
   wire ack_ls    = ls_q[1];
   wire addr_low  = ls_q[0];
   wire scl_rise  = scl_s & ~scl_q;
   wire scl_fall  = ~scl_s & scl_q;
   wire start_c   = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_c    = scl_s & scl_q & ~sda_q & sda_s;
   wire done      = ack_ls ^ ack_seen;
   wire addr_hit  = sh[7:1] == {irp_pkg::ADDR_HIGH, addr_low};
   wire hold_fifo = req_addr == irp_pkg::REG_FIFO_DATA;
   wire [7:0] next_ptr = hold_fifo ? ptr : ptr + 8'h01;
   wire scl_low   = (state == irp_pkg::D_WAIT) | ((state == irp_pkg::D_ACK_RX) & wr_pend);

   // Open-drain pins: only ever pull low
   assign bus.scl_d_o    = 1'b0;
   assign bus.sda_d_o    = 1'b0;
   assign bus.scl_d_oe_n = ~scl_low;
   assign bus.sda_d_oe_n = ~sda_low;

   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         ack_seen <= 1'b0;
      end else begin
         scl_q    <= scl_s;
         sda_q    <= sda_s;
         ack_seen <= ack_ls;
      end
   end

   // Target-only engine; the master owns every transfer
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         state     <= irp_pkg::D_IDLE;
         sh        <= 8'h00;
         cnt       <= 4'h0;
         rw        <= 1'b0;
         first     <= 1'b0;
         ptr       <= 8'h00;
         wr_pend   <= 1'b0;
         sda_low   <= 1'b0;
         req_t     <= 1'b0;
         req_we    <= 1'b0;
         req_addr  <= 8'h00;
         req_wdata <= 8'h00;
      end else if (stop_c) begin
         state   <= irp_pkg::D_IDLE;
         sda_low <= 1'b0;
         wr_pend <= 1'b0;
      end else if (start_c) begin
         state   <= irp_pkg::D_ADDR;
         cnt     <= 4'h0;
         sda_low <= 1'b0;
         wr_pend <= 1'b0;
      end else begin
         unique case (state)
            irp_pkg::D_IDLE: begin
               sda_low <= 1'b0;
            end
            irp_pkg::D_ADDR: begin
               if (scl_rise) begin
                  sh  <= {sh[6:0], sda_s};
                  cnt <= cnt + 4'h1;
               end else if (scl_fall && cnt == irp_pkg::RX_BITS) begin
                  if (addr_hit) begin
                     sda_low <= 1'b1;
                     rw      <= sh[0];
                     first   <= 1'b1;
                     state   <= irp_pkg::D_ACK_A;
                  end else begin
                     state <= irp_pkg::D_IDLE;
                  end
               end
            end
            irp_pkg::D_ACK_A: begin
               if (scl_fall) begin
                  sda_low <= 1'b0;
                  cnt     <= 4'h0;
                  if (rw) begin
                     req_t    <= ~req_t;
                     req_we   <= 1'b0;
                     req_addr <= ptr;
                     state    <= irp_pkg::D_WAIT;
                  end else begin
                     state <= irp_pkg::D_RX;
                  end
               end
            end
            irp_pkg::D_RX: begin
               if (scl_rise) begin
                  sh  <= {sh[6:0], sda_s};
                  cnt <= cnt + 4'h1;
               end else if (scl_fall && cnt == irp_pkg::RX_BITS) begin
                  sda_low <= 1'b1;
                  state   <= irp_pkg::D_ACK_RX;
                  if (first) begin
                     ptr <= sh;
                  end else begin
                     req_t     <= ~req_t;
                     req_we    <= 1'b1;
                     req_addr  <= ptr;
                     req_wdata <= sh;
                     wr_pend   <= 1'b1;
                  end
               end
            end
            irp_pkg::D_ACK_RX: begin
               if (done && wr_pend) begin
                  wr_pend <= 1'b0;
                  ptr     <= next_ptr;
               end else if (scl_fall && !wr_pend) begin
                  sda_low <= 1'b0;
                  first   <= 1'b0;
                  cnt     <= 4'h0;
                  state   <= irp_pkg::D_RX;
               end
            end
            irp_pkg::D_WAIT: begin
               if (done) begin
                  sh      <= rdata;
                  ptr     <= next_ptr;
                  cnt     <= 4'h0;
                  sda_low <= ~rdata[7];
                  state   <= irp_pkg::D_TX;
               end
            end
            irp_pkg::D_TX: begin
               if (scl_fall) begin
                  if (cnt == irp_pkg::TX_LAST) begin
                     sda_low <= 1'b0;
                     state   <= irp_pkg::D_ACK_TX;
                  end else begin
                     sh      <= {sh[6:0], 1'b0};
                     sda_low <= ~sh[6];
                     cnt     <= cnt + 4'h1;
                  end
               end
            end
            irp_pkg::D_ACK_TX: begin
               if (scl_rise) begin
                  first <= sda_s;
               end else if (scl_fall) begin
                  if (first) begin
                     state <= irp_pkg::D_IDLE;
                  end else begin
                     req_t    <= ~req_t;
                     req_we   <= 1'b0;
                     req_addr <= ptr;
                     state    <= irp_pkg::D_WAIT;
                  end
               end
            end
         endcase
      end
   end

   // Register side: request toggle in, acknowledge toggle out
   logic [1:0]              cs_q;
   logic                    req_q;
   logic [7:0]              cfg [irp_pkg::CFG_NUM];
   logic [7:0]              mem [irp_pkg::FIFO_DEPTH];
   logic [irp_pkg::FIFO_AW-1:0] wptr;
   logic [irp_pkg::FIFO_AW-1:0] rptr;
   logic [9:0]              count;

   irp_sync2 #(.W(2), .RST_VAL(2'h0)) u_reg_sync (
      .clk (clk),
      .rst (rst),
      .d   ({req_t, address_low_bit_strap}),
      .q   (cs_q)
   );

   wire        req_edge  = cs_q[1] ^ req_q;
   wire        strap_cs  = cs_q[0];
   wire [7:0]  cofs      = req_addr - irp_pkg::REG_CFG_BASE;
   wire [7:0]  sofs      = req_addr - irp_pkg::REG_SENS_BASE;
   wire        is_cfg    = req_addr >= irp_pkg::REG_CFG_BASE && cofs < irp_pkg::CFG_NUM_B;
   wire        is_sens   = req_addr >= irp_pkg::REG_SENS_BASE && sofs < irp_pkg::SENS_NUM_B;
   wire [63:0] sens_flat = {rate_x, rate_y, rate_z, temp_sample};
   wire [7:0]  sens_byte = sens_flat[(irp_pkg::SENS_BYTES - 1 - int'(sofs[2:0]))
                                     * irp_pkg::BYTE_BITS +: irp_pkg::BYTE_BITS];
   wire        empty     = count == 10'h000;
   wire        push      = fifo_push_valid & fifo_push_ready;
   wire        pop       = req_edge & ~req_we & hold_fifo & ~empty;
   wire [7:0]  rd_mux    =
      is_cfg ? cfg[cofs[2:0]] :
      is_sens ? sens_byte :
      (req_addr == irp_pkg::REG_FIFO_CNT_H) ? {6'h00, count[9:8]} :
      (req_addr == irp_pkg::REG_FIFO_CNT_L) ? count[7:0] :
      (hold_fifo && !empty) ? mem[rptr] :
      (req_addr == irp_pkg::REG_IDENTITY) ? {1'b0, irp_pkg::ADDR_HIGH, strap_cs} :
      8'h00;

   assign fifo_push_ready = count != irp_pkg::FIFO_FULL_CNT;
   assign fifo_count      = count;

   for (genvar g = 0; g < irp_pkg::CFG_NUM; g++) begin : g_cfg
      assign cfg_bits[g*irp_pkg::BYTE_BITS +: irp_pkg::BYTE_BITS] = cfg[g];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         req_q <= 1'b0;
         ack_t <= 1'b0;
         rdata <= 8'h00;
         for (int i = 0; i < irp_pkg::CFG_NUM; i++) begin
            cfg[i] <= irp_pkg::CFG_RESET;
         end
      end else begin
         req_q <= cs_q[1];
         if (req_edge) begin
            ack_t <= ~ack_t;
            if (!req_we) begin
               rdata <= rd_mux;
            end else if (is_cfg) begin
               cfg[cofs[2:0]] <= req_wdata;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= 10'h000;
      end else begin
         if (push) begin
            wptr <= wptr + 9'h001;
         end
         if (pop) begin
            rptr <= rptr + 9'h001;
         end
         count <= count + {9'h000, push} - {9'h000, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr] <= fifo_push_data;
      end
   end
endmodule

//--- tb/i2c_slave_register_port_bench.sv
module i2c_slave_register_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst, link_rst, strap, cmd_valid, cmd_read, cmd_addr_low, fifo_push_valid;
   logic [7:0]  fifo_push_data, cmd_ptr, cmd_len, wr_data, rd_data;
   logic [15:0] rate_x, rate_y, rate_z, temp_sample;
   logic        cmd_ready, wr_take, rd_valid, done, nack_err, fifo_push_ready;
   logic [9:0]  fifo_count;
   logic [63:0] cfg_bits;
   logic [7:0]  rq[$], wq[$];
   int          failures = 0, n_checks = 0, cyc = 0;
   irp_bus_if bus ();
   always #5 clk = ~clk;
   initial begin #2.3; forever #15 link_clk = ~link_clk; end
   irp_target irp_target_inst (.link_clk(link_clk), .link_rst(link_rst), .bus(bus.target),
      .clk(clk), .rst(rst), .address_low_bit_strap(strap), .rate_x(rate_x), .rate_y(rate_y),
      .rate_z(rate_z), .temp_sample(temp_sample), .fifo_push_valid(fifo_push_valid),
      .fifo_push_data(fifo_push_data), .fifo_push_ready(fifo_push_ready),
      .fifo_count(fifo_count), .cfg_bits(cfg_bits));
   irp_master irp_master_inst (.clk(clk), .rst(rst), .bus(bus.master), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr_low(cmd_addr_low),
      .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
      .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err));
   irp_bus_checker irp_bus_checker_inst (.link_clk(link_clk), .link_rst(link_rst),
      .scl_d_o(bus.scl_d_o), .scl_d_oe_n(bus.scl_d_oe_n), .sda_d_o(bus.sda_d_o),
      .sda_d_oe_n(bus.sda_d_oe_n), .scl(bus.scl), .sda(bus.sda));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 150000) begin
         failures++;
         complete_run;
      end
   end
   // One command from take to done, collecting read bytes
   task automatic xfer(input logic r, input logic a, input logic [7:0] p, input logic [7:0] n);
      rq = {};
      {cmd_read, cmd_addr_low, cmd_ptr, cmd_len, cmd_valid} = {r, a, p, n, 1'b1};
      wr_data = wq.size() ? wq.pop_front() : 8'h00;
      @(negedge clk) cmd_valid = 1'b0;
      while (done !== 1'b1) begin
         @(negedge clk);
         if (rd_valid) rq.push_back(rd_data);
         if (wr_take) wr_data = wq.size() ? wq.pop_front() : 8'h00;
      end
   endtask
   task automatic s_wr_rd;
      wq = {8'ha1, 8'hb2, 8'hc3};
      xfer(1'b0, 1'b0, 8'h00, 8'h03);
      chk("cfg", cfg_bits[23:0], 24'hc3b2a1);
      xfer(1'b1, 1'b0, 8'h01, 8'h02);
      chk("rd", {rq[0], rq[1]}, 16'hb2c3);
      chk("nack", nack_err, 1'b0);
   endtask
   task automatic s_sens;
      xfer(1'b1, 1'b0, irp_pkg::REG_SENS_BASE, 8'h08);
      chk("sens_xy", {rq[0], rq[1], rq[2], rq[3]}, {rate_x, rate_y});
      chk("sens_zt", {rq[4], rq[5], rq[6], rq[7]}, {rate_z, temp_sample});
   endtask
   task automatic s_addr;
      for (int b = 0; b < 2; b++) begin
         strap = b[0];
         repeat (10) @(negedge clk);
         xfer(1'b1, b[0], irp_pkg::REG_IDENTITY, 8'h01);
         chk("ident", rq[0], {1'b0, irp_pkg::ADDR_HIGH, b[0]});
         wq = {8'hff};
         xfer(1'b0, ~b[0], 8'h00, 8'h01);
         chk("miss", nack_err, 1'b1);
         chk("miss_cfg", cfg_bits[7:0], 8'ha1);
      end
   endtask
   task automatic s_fifo;
      {fifo_push_valid, fifo_push_data} = {1'b1, 8'h40};
      repeat (3) @(negedge clk) fifo_push_data++;
      fifo_push_valid = 1'b0;
      @(negedge clk);
      chk("cnt", fifo_count, 10'h003);
      xfer(1'b1, 1'b1, irp_pkg::REG_FIFO_CNT_H, 8'h02);
      chk("cnt_reg", {rq[0], rq[1]}, 16'h0003);
      xfer(1'b1, 1'b1, irp_pkg::REG_FIFO_DATA, 8'h03);
      chk("fifo", {rq[0], rq[1], rq[2]}, 24'h404142);
      chk("cnt_end", fifo_count, 10'h000);
   endtask
   initial begin
      {rst, link_rst, strap, cmd_valid, cmd_read, cmd_addr_low} = 6'h30;
      {fifo_push_valid, fifo_push_data, cmd_ptr, cmd_len, wr_data} = 33'h0;
      {rate_x, rate_y, rate_z, temp_sample} = 64'h1234_5678_9abc_def0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(posedge link_clk);
      @(negedge clk) link_rst = 1'b0;
      repeat (12) @(negedge clk);
      s_wr_rd;
      s_sens;
      s_addr;
      s_fifo;
      complete_run;
   end
endmodule

//--- tb/irp_bus_checker.sv
module irp_bus_checker (
   // Link clock and reset
   input wire logic link_clk,
   input wire logic link_rst,
   // Target drive and wired lines
   input wire logic scl_d_o,
   input wire logic scl_d_oe_n,
   input wire logic sda_d_o,
   input wire logic sda_d_oe_n,
   input wire logic scl,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge link_clk); endclocking
   default disable iff (link_rst);
   drv_low_a: assert property (scl_d_o == 1'b0 && sda_d_o == 1'b0)
      else $error("target drives a line high");
   sda_quiet_a: assert property ($changed(sda_d_oe_n) |-> !scl)
      else $error("target moved data while clock high");
   ack_hold_a: assert property (scl && !sda_d_oe_n |=> !sda_d_oe_n || !scl)
      else $error("target let data go during clock high");
   stretch_low_a: assert property ($fell(scl_d_oe_n) |-> !$past(scl, 2))
      else $error("target stretch began while clock high");
   stretch_len_a: assert property ($fell(scl_d_oe_n) |-> ##[1:60] $rose(scl_d_oe_n))
      else $error("target stretch too long");
   stop_idle_a: assert property (scl && $rose(sda) |=> (sda_d_oe_n && scl_d_oe_n) [*4])
      else $error("target active after stop");
   start_rel_a: assert property (scl && $fell(sda) |=> (sda_d_oe_n && scl_d_oe_n) [*3])
      else $error("target active after start");
   byte_len_a: assert property ($fell(sda_d_oe_n) |-> ##[1:800] $rose(sda_d_oe_n))
      else $error("target held data beyond one byte");
   cover property ($fell(scl_d_oe_n));
   cover property (scl && $rose(sda));
   cover property (scl && $fell(sda));
endmodule
